// File: inc/pca_regs_params.svh
/*
 * register offsets, field widths and reset values for the counter and
 * capture register slice. assumes an 8-bit special function register bus.
 */
`ifndef PCA_REGS_PARAMS_SVH
`define PCA_REGS_PARAMS_SVH

`define COUNTER_LOW_BYTE_ADDR 8'hF9
`define COUNTER_HIGH_BYTE_ADDR 8'hFA
`define CAPTURE0_LOW_ADDR 8'hFB
`define CAPTURE0_HIGH_ADDR 8'hFC
`define CAPTURE1_LOW_ADDR 8'hE9
`define CAPTURE1_HIGH_ADDR 8'hEA
`define CAPTURE2_LOW_ADDR 8'hEB
`define CAPTURE2_HIGH_ADDR 8'hEC
`define CAPTURE3_LOW_ADDR 8'hED
`define CAPTURE3_HIGH_ADDR 8'hEE
`define CAPTURE4_LOW_ADDR 8'hFD
`define CAPTURE4_HIGH_ADDR 8'hFE
`define CAPTURE5_LOW_ADDR 8'hD2
`define CAPTURE5_HIGH_ADDR 8'hD3

`define CHANNELS 6
`define BYTE_RESET 8'h00
`define WORD_RESET 16'h0000
`define CHAN_RESET 6'h00
`define UNMAPPED_READ 8'h00
`define COUNTER_STEP 16'h0001

`endif

// File: inc/pca_regs_pkg.sv
/*
 * types shared by the counter and capture register slice.
 * assumes the special function register bus of the processor core.
 */
package pca_regs_pkg;

    // one special function register access, held for one cycle
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } sfr_req_s;

    // channel index of a decoded capture address
    typedef logic [2:0] chan_idx_t;

endpackage

// File: hw/reload_mem.sv
/*
 * six 16-bit auto-reload words with per-byte write and registered read.
 * assumes write and read addresses below six; other writes are ignored, other reads return zero.
 */
`timescale 1ns/100ps
`default_nettype none
`include "pca_regs_params.svh"

module reload_mem (
    input wire logic ref_clk, // core clock
    input wire logic nrst, // asynchronous reset, active low
    input wire pca_regs_pkg::chan_idx_t waddr, // word written
    input wire logic wr_lo, // write low byte
    input wire logic wr_hi, // write high byte
    input wire logic [7:0] wdata, // byte written
    input wire pca_regs_pkg::chan_idx_t raddr, // word read
    output logic [15:0] rdata // read word, one cycle late
);

    logic [15:0] mem [`CHANNELS];
    logic [15:0] next_mem [`CHANNELS];
    logic [15:0] next_rdata;

    // byte merge for the addressed word, read of the next word
    always_comb begin
        for (int i = 0; i < `CHANNELS; i++) begin
            next_mem[i] = mem[i];
            if (waddr == 3'(i)) begin
                if (wr_lo) begin
                    next_mem[i][7:0] = wdata;
                end
                if (wr_hi) begin
                    next_mem[i][15:8] = wdata;
                end
            end
        end
        next_rdata = (raddr < 3'(`CHANNELS)) ? mem[raddr] : `WORD_RESET;
    end

    // storage and read register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < `CHANNELS; i++) begin
                mem[i] <= `WORD_RESET;
            end
            rdata <= `WORD_RESET;
        end else begin
            for (int i = 0; i < `CHANNELS; i++) begin
                mem[i] <= next_mem[i];
            end
            rdata <= next_rdata;
        end
    end

endmodule
`default_nettype wire

// File: hw/pca_counter_capture_regs.sv
/*
 * counter and capture/compare register slice of the counter array,
 * reached by the core over the special function register bus.
 * assumes one-cycle rd/wr strobes on ref_clk and a counter tick pulse
 * on the same clock; watchdog, reload select and cycle length arrive
 * as levels from their own registers elsewhere.
 */
// How it works
// - the 16-bit counter is seen as a low byte and a high byte register.
// - high byte reads return a snapshot taken when the low byte is read.
// - counter low byte writes are dropped while the watchdog is enabled.
// - counter high byte writes are dropped while the watchdog is enabled.
// - each of six channels has a low capture byte at its own address.
// - each channel has a high capture byte at its own address.
// - with reload select set, those addresses reach the reload word.
// - a write to a channel low byte clears its comparator enable.
// - a write to a channel high byte sets its comparator enable.
// - a channel compares with the counter only while enabled.
// - cycle length select picks an 8, 9, 10 or 11 bit PWM cycle.
`timescale 1ns/100ps
`default_nettype none
`include "pca_regs_params.svh"

module pca_counter_capture_regs (
    input wire logic ref_clk, // 20 MHz core clock
    input wire logic nrst, // asynchronous reset, active low
    input wire pca_regs_pkg::sfr_req_s sfr_req, // register access
    input wire logic counter_tick, // counter advance enable pulse
    input wire logic watchdog_enable, // watchdog lock level
    input wire logic reload_select, // capture addresses reach reload
    input wire logic [1:0] cycle_length_select, // pwm cycle length
    output logic [7:0] sfr_rdata, // read data, two cycles late
    output logic sfr_rvalid, // read data valid pulse
    output logic [15:0] counter_value, // running counter
    output logic [5:0] comparator_enable, // per channel enables
    output logic [5:0] compare_match, // per channel match pulses
    output logic cycle_overflow // pwm cycle wrap pulse
);

    // address decode results
    logic hit_cnt_lo;
    logic hit_cnt_hi;
    logic hit_cap;
    logic hit_hi;
    pca_regs_pkg::chan_idx_t hit_ch;

    // decode of the bus address into counter bytes and channel bytes
    always_comb begin
        hit_cnt_lo = 1'b0;
        hit_cnt_hi = 1'b0;
        hit_cap = 1'b1;
        hit_hi = 1'b0;
        hit_ch = 3'h0;
        if (sfr_req.addr == `COUNTER_LOW_BYTE_ADDR) begin
            hit_cnt_lo = 1'b1;
            hit_cap = 1'b0;
        end else if (sfr_req.addr == `COUNTER_HIGH_BYTE_ADDR) begin
            hit_cnt_hi = 1'b1;
            hit_cap = 1'b0;
        end else if (sfr_req.addr == `CAPTURE0_LOW_ADDR) begin
            hit_ch = 3'h0;
        end else if (sfr_req.addr == `CAPTURE0_HIGH_ADDR) begin
            hit_ch = 3'h0;
            hit_hi = 1'b1;
        end else if (sfr_req.addr == `CAPTURE1_LOW_ADDR) begin
            hit_ch = 3'h1;
        end else if (sfr_req.addr == `CAPTURE1_HIGH_ADDR) begin
            hit_ch = 3'h1;
            hit_hi = 1'b1;
        end else if (sfr_req.addr == `CAPTURE2_LOW_ADDR) begin
            hit_ch = 3'h2;
        end else if (sfr_req.addr == `CAPTURE2_HIGH_ADDR) begin
            hit_ch = 3'h2;
            hit_hi = 1'b1;
        end else if (sfr_req.addr == `CAPTURE3_LOW_ADDR) begin
            hit_ch = 3'h3;
        end else if (sfr_req.addr == `CAPTURE3_HIGH_ADDR) begin
            hit_ch = 3'h3;
            hit_hi = 1'b1;
        end else if (sfr_req.addr == `CAPTURE4_LOW_ADDR) begin
            hit_ch = 3'h4;
        end else if (sfr_req.addr == `CAPTURE4_HIGH_ADDR) begin
            hit_ch = 3'h4;
            hit_hi = 1'b1;
        end else if (sfr_req.addr == `CAPTURE5_LOW_ADDR) begin
            hit_ch = 3'h5;
        end else if (sfr_req.addr == `CAPTURE5_HIGH_ADDR) begin
            hit_ch = 3'h5;
            hit_hi = 1'b1;
        end else begin
            hit_cap = 1'b0;
        end
    end

    // strobes into the capture words and the reload memory
    // comparator enable side effects follow any channel write, reload or not
    logic cap_wr;
    logic rel_wr_lo;
    logic rel_wr_hi;
    assign cap_wr = sfr_req.wr && hit_cap && !reload_select;
    assign rel_wr_lo = sfr_req.wr && hit_cap && reload_select && !hit_hi;
    assign rel_wr_hi = sfr_req.wr && hit_cap && reload_select && hit_hi;

    // reload word read alongside every access, used only when selected
    logic [15:0] reload_word;

    reload_mem u_reload (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .waddr(hit_ch),
        .wr_lo(rel_wr_lo),
        .wr_hi(rel_wr_hi),
        .wdata(sfr_req.wdata),
        .raddr(hit_ch),
        .rdata(reload_word)
    );

    // counter, snapshot and pwm cycle wrap
    logic [7:0] snapshot;
    logic [7:0] next_snapshot;
    logic [15:0] next_counter;
    logic next_overflow;
    logic [10:0] cycle_mask;

    always_comb begin
        next_counter = counter_value;
        next_snapshot = snapshot;
        if (counter_tick) begin
            next_counter = counter_value + `COUNTER_STEP;
        end
        if (sfr_req.wr && hit_cnt_lo && !watchdog_enable) begin
            next_counter[7:0] = sfr_req.wdata;
        end
        if (sfr_req.wr && hit_cnt_hi && !watchdog_enable) begin
            next_counter[15:8] = sfr_req.wdata;
        end
        if (sfr_req.rd && hit_cnt_lo) begin
            next_snapshot = counter_value[15:8];
        end
        case (cycle_length_select)
            2'h0: cycle_mask = 11'h0FF;
            2'h1: cycle_mask = 11'h1FF;
            2'h2: cycle_mask = 11'h3FF;
            default: cycle_mask = 11'h7FF;
        endcase
        next_overflow = counter_tick &&
            ((counter_value[10:0] & cycle_mask) == cycle_mask);
    end

    // counter, snapshot and wrap registers
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            counter_value <= `WORD_RESET;
            snapshot <= `BYTE_RESET;
            cycle_overflow <= 1'b0;
        end else begin
            counter_value <= next_counter;
            snapshot <= next_snapshot;
            cycle_overflow <= next_overflow;
        end
    end

    // per channel capture word, comparator enable and match
    logic [15:0] capture_value [`CHANNELS];

    for (genvar c = 0; c < `CHANNELS; c++) begin : g_chan
        logic [15:0] next_capture;
        logic next_enable;
        logic next_match;
        logic this_ch;

        assign this_ch = hit_cap && (hit_ch == 3'(c));

        always_comb begin
            next_capture = capture_value[c];
            next_enable = comparator_enable[c];
            if (cap_wr && this_ch && !hit_hi) begin
                next_capture[7:0] = sfr_req.wdata;
            end
            if (cap_wr && this_ch && hit_hi) begin
                next_capture[15:8] = sfr_req.wdata;
            end
            if (sfr_req.wr && this_ch) begin
                next_enable = hit_hi;
            end
            next_match = comparator_enable[c] &&
                (counter_value == capture_value[c]);
        end

        // channel word, enable and match registers
        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                capture_value[c] <= `WORD_RESET;
                comparator_enable[c] <= 1'b0;
                compare_match[c] <= 1'b0;
            end else begin
                capture_value[c] <= next_capture;
                comparator_enable[c] <= next_enable;
                compare_match[c] <= next_match;
            end
        end
    end

    // read path: stage one picks a byte, stage two adds reload words
    logic [7:0] rd_byte;
    logic rd_pend;
    logic rd_rel;
    logic rd_hi;
    logic [7:0] next_rd_byte;
    logic [7:0] next_rdata;
    logic next_rd_pend;
    logic next_rd_rel;
    logic next_rd_hi;
    logic next_rvalid;

    always_comb begin
        next_rd_byte = `UNMAPPED_READ;
        if (hit_cnt_lo) begin
            next_rd_byte = counter_value[7:0];
        end else if (hit_cnt_hi) begin
            next_rd_byte = snapshot;
        end else if (hit_cap && hit_hi) begin
            next_rd_byte = capture_value[hit_ch][15:8];
        end else if (hit_cap) begin
            next_rd_byte = capture_value[hit_ch][7:0];
        end
        next_rdata = rd_byte;
        if (rd_rel) begin
            next_rdata = rd_hi ? reload_word[15:8] : reload_word[7:0];
        end
        // reload words leave their memory one cycle after the request,
        // so the select travels with the pending read
        next_rd_pend = sfr_req.rd;
        next_rd_rel = sfr_req.rd && hit_cap && reload_select;
        next_rd_hi = hit_hi;
        next_rvalid = rd_pend;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rd_byte <= `BYTE_RESET;
            rd_pend <= 1'b0;
            rd_rel <= 1'b0;
            rd_hi <= 1'b0;
            sfr_rdata <= `BYTE_RESET;
            sfr_rvalid <= 1'b0;
        end else begin
            rd_byte <= next_rd_byte;
            rd_pend <= next_rd_pend;
            rd_rel <= next_rd_rel;
            rd_hi <= next_rd_hi;
            sfr_rdata <= next_rdata;
            sfr_rvalid <= next_rvalid;
        end
    end

endmodule
`default_nettype wire

// File: tb/core_model.sv
/*
 * processor core model issuing special function register accesses.
 * assumes one-cycle strobes and read data a fixed count of cycles late.
 */
`timescale 1ns/100ps
`default_nettype none

module core_model (
    input wire logic ref_clk, // core clock
    input wire logic [7:0] sfr_rdata, // read byte
    input wire logic sfr_rvalid, // read data valid pulse
    output var pca_regs_pkg::sfr_req_s sfr_req // register access
);
    initial sfr_req = '0;

    // one write strobe, then the lines are released inverted
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        sfr_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(negedge ref_clk);
        sfr_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask

    // one read strobe, then a bounded wait for the answer
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic to);
        @(negedge ref_clk);
        sfr_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: ~sfr_req.wdata};
        @(negedge ref_clk);
        sfr_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~sfr_req.wdata};
        to = 1'b1;
        d = 8'h00;
        for (int i = 0; i < 4 && to; i++) begin
            if (sfr_rvalid) begin
                d = sfr_rdata;
                to = 1'b0;
            end else begin
                @(negedge ref_clk);
            end
        end
    endtask
endmodule
`default_nettype wire

// File: tb/pca_regs_props.sv
/*
 * assertions on the counter and capture register slice ports.
 * assumes a single clock domain and the package request struct.
 */
`timescale 1ns/100ps
`default_nettype none
`include "pca_regs_params.svh"

module pca_regs_props (
    input wire logic ref_clk, // core clock
    input wire logic nrst, // reset, active low
    input wire pca_regs_pkg::sfr_req_s sfr_req, // register access
    input wire logic counter_tick, // counter advance
    input wire logic watchdog_enable, // counter write lock
    input wire logic [1:0] cycle_length_select, // pwm cycle length
    input wire logic [7:0] sfr_rdata, // read byte
    input wire logic sfr_rvalid, // read valid
    input wire logic [15:0] counter_value, // running counter
    input wire logic [5:0] comparator_enable, // channel enables
    input wire logic [5:0] compare_match, // match pulses
    input wire logic cycle_overflow // cycle wrap pulse
);
    localparam logic [47:0] LO_A = {`CAPTURE5_LOW_ADDR, `CAPTURE4_LOW_ADDR,
        `CAPTURE3_LOW_ADDR, `CAPTURE2_LOW_ADDR, `CAPTURE1_LOW_ADDR,
        `CAPTURE0_LOW_ADDR};
    localparam logic [47:0] HI_A = {`CAPTURE5_HIGH_ADDR, `CAPTURE4_HIGH_ADDR,
        `CAPTURE3_HIGH_ADDR, `CAPTURE2_HIGH_ADDR, `CAPTURE1_HIGH_ADDR,
        `CAPTURE0_HIGH_ADDR};
    logic [5:0] lo_hit;
    logic [5:0] hi_hit;
    logic [10:0] ovf_mask;
    logic lo_cnt;
    logic hi_cnt;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // channel write decode and wrap bit mask
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            lo_hit[i] = sfr_req.wr && sfr_req.addr == LO_A[8*i +: 8];
            hi_hit[i] = sfr_req.wr && sfr_req.addr == HI_A[8*i +: 8];
        end
        ovf_mask = 11'h7FF >> (2'h3 - cycle_length_select);
        lo_cnt = sfr_req.addr == `COUNTER_LOW_BYTE_ADDR;
        hi_cnt = sfr_req.addr == `COUNTER_HIGH_BYTE_ADDR;
    end

    chk_read_latency: assert property (
        sfr_req.rd |-> ##2 sfr_rvalid) else $error("read answer late");
    chk_valid_cause: assert property (
        sfr_rvalid |-> $past(sfr_req.rd, 2)) else $error("stray read valid");
    chk_low_read_data: assert property (
        sfr_req.rd && lo_cnt |-> ##2 sfr_rdata == $past(counter_value[7:0], 2))
        else $error("counter low read wrong");
    chk_low_write_clr: assert property (
        |lo_hit |=> (comparator_enable & $past(lo_hit)) == 6'h00)
        else $error("enable not cleared");
    chk_high_write_set: assert property (
        |hi_hit |=> (comparator_enable & $past(hi_hit)) == $past(hi_hit))
        else $error("enable not set");
    chk_enable_hold: assert property (
        !(|lo_hit || |hi_hit) |=> $stable(comparator_enable))
        else $error("enable changed without write");
    chk_lock_low: assert property (
        watchdog_enable && sfr_req.wr && lo_cnt && !counter_tick
        |=> $stable(counter_value)) else $error("locked low write landed");
    chk_lock_high: assert property (
        watchdog_enable && sfr_req.wr && hi_cnt && !counter_tick
        |=> $stable(counter_value)) else $error("locked high write landed");
    chk_low_write: assert property (
        !watchdog_enable && sfr_req.wr && lo_cnt
        |=> counter_value[7:0] == $past(sfr_req.wdata))
        else $error("counter low write lost");
    chk_match_gate: assert property (
        (compare_match & ~$past(comparator_enable)) == 6'h00)
        else $error("match on disabled channel");
    chk_wrap_cause: assert property (
        cycle_overflow |-> $past(counter_tick)
        && &($past(counter_value[10:0]) | ~$past(ovf_mask)))
        else $error("cycle wrap at wrong count");
    chk_wrap_fire: assert property (
        counter_tick && &(counter_value[10:0] | ~ovf_mask)
        |=> cycle_overflow) else $error("cycle wrap missed");
endmodule

bind pca_counter_capture_regs pca_regs_props chk (.ref_clk, .nrst,
    .sfr_req, .counter_tick, .watchdog_enable, .cycle_length_select,
    .sfr_rdata, .sfr_rvalid, .counter_value, .comparator_enable,
    .compare_match, .cycle_overflow);
`default_nettype wire

// File: tb/tb_top.sv
/*
 * self-checking bench for the counter and capture register slice.
 * assumes the core model drives every register access.
 */
`timescale 1ns/100ps
`default_nettype none
`include "pca_regs_params.svh"

module tb_top;
    logic ref_clk = 0, nrst = 0, counter_tick = 0, watchdog_enable = 0;
    logic reload_select = 0, sfr_rvalid, cycle_overflow, to;
    logic [1:0] cycle_length_select = 2'h0;
    pca_regs_pkg::sfr_req_s sfr_req;
    logic [7:0] sfr_rdata, rd_b, v;
    logic [15:0] counter_value, cnt, w;
    logic [5:0] comparator_enable, compare_match, m_exp;
    logic [7:0] cap_m[12], rel_m[12];
    logic [7:0] cap_a[12] = '{`CAPTURE0_LOW_ADDR, `CAPTURE0_HIGH_ADDR,
        `CAPTURE1_LOW_ADDR, `CAPTURE1_HIGH_ADDR, `CAPTURE2_LOW_ADDR,
        `CAPTURE2_HIGH_ADDR, `CAPTURE3_LOW_ADDR, `CAPTURE3_HIGH_ADDR,
        `CAPTURE4_LOW_ADDR, `CAPTURE4_HIGH_ADDR, `CAPTURE5_LOW_ADDR,
        `CAPTURE5_HIGH_ADDR};
    int err_count = 0, compares = 0, n, ovf, wraps, msk;

    pca_counter_capture_regs uut (.ref_clk, .nrst, .sfr_req, .counter_tick,
        .watchdog_enable, .reload_select, .cycle_length_select, .sfr_rdata,
        .sfr_rvalid, .counter_value, .comparator_enable, .compare_match,
        .cycle_overflow);
    core_model cpu (.ref_clk, .sfr_rdata, .sfr_rvalid, .sfr_req);

    // 20 MHz core clock
    initial forever #25 ref_clk = ~ref_clk;

    // compare and count
    task automatic check(input string nm, input logic [15:0] s, e);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask

    // read through the core model and compare the byte
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        cpu.rd(a, rd_b, to);
        if (to) begin
            err_count++;
            complete_run();
        end else begin
            check("rdata", 16'(rd_b), 16'(e));
        end
    endtask

    // counts, verdict, end of run
    task automatic complete_run();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // main sequence
    initial begin
        v = 8'($urandom(32'h6A9A));
        repeat (8) @(negedge ref_clk);
        nrst = 1;
        for (int i = 0; i < 12; i++) rd(cap_a[i], `BYTE_RESET);
        rd(`COUNTER_HIGH_BYTE_ADDR, `BYTE_RESET);
        cpu.wr(8'hA0, 8'h77);
        rd(8'hA0, `UNMAPPED_READ);
        // low byte before high byte, into captures and then reloads
        for (int s = 0; s < 2; s++) begin
            reload_select = s[0];
            for (int i = 0; i < 12; i++) begin
                v = 8'($urandom);
                cpu.wr(cap_a[i], v);
                if (s == 1) rel_m[i] = v;
                else cap_m[i] = v;
                check("en", 16'(comparator_enable[i/2]), 16'(i%2));
            end
        end
        for (int s = 0; s < 2; s++) begin
            reload_select = s[0];
            for (int i = 0; i < 12; i++)
                rd(cap_a[i], s == 1 ? rel_m[i] : cap_m[i]);
        end
        watchdog_enable = 1;
        cpu.wr(`COUNTER_LOW_BYTE_ADDR, 8'h5A);
        cpu.wr(`COUNTER_HIGH_BYTE_ADDR, 8'hA5);
        rd(`COUNTER_LOW_BYTE_ADDR, 8'h00);
        rd(`COUNTER_HIGH_BYTE_ADDR, 8'h00);
        watchdog_enable = 0;
        // snapshot survives ticks until the next low byte read
        for (int k = 0; k < 4; k++) begin
            cycle_length_select = 2'(k);
            w = 16'($urandom);
            cpu.wr(`COUNTER_LOW_BYTE_ADDR, w[7:0]);
            cpu.wr(`COUNTER_HIGH_BYTE_ADDR, w[15:8]);
            cnt = w;
            rd(`COUNTER_LOW_BYTE_ADDR, cnt[7:0]);
            n = 256 + $urandom_range(300);
            // wraps expected from the cycle length: 8 + select bits
            msk = (1 << (8 + k)) - 1;
            wraps = 0;
            for (int j = 0; j < n; j++)
                if (((int'(cnt) + j) & msk) == msk) wraps++;
            ovf = 0;
            counter_tick = 1;
            repeat (n) begin
                @(negedge ref_clk);
                if (cycle_overflow !== 1'b0) ovf++;
            end
            counter_tick = 0;
            cnt = cnt + 16'(n);
            check("counter", counter_value, cnt);
            check("wraps", 16'(ovf), 16'(wraps));
            rd(`COUNTER_HIGH_BYTE_ADDR, w[15:8]);
            rd(`COUNTER_LOW_BYTE_ADDR, cnt[7:0]);
            rd(`COUNTER_HIGH_BYTE_ADDR, cnt[15:8]);
        end
        // counter parked on channel 0's compare value, all channels enabled
        reload_select = 0;
        w = {cap_m[1], cap_m[0]};
        cpu.wr(`COUNTER_LOW_BYTE_ADDR, w[7:0]);
        cpu.wr(`COUNTER_HIGH_BYTE_ADDR, w[15:8]);
        for (int c = 0; c < 6; c++)
            m_exp[c] = {cap_m[2*c+1], cap_m[2*c]} == w;
        @(negedge ref_clk);
        check("match", 16'(compare_match), 16'(m_exp));
        // a lone low byte write disables channel 0, so its match drops
        cpu.wr(cap_a[0], cap_m[0]);
        m_exp[0] = 1'b0;
        @(negedge ref_clk);
        check("match", 16'(compare_match), 16'(m_exp));
        complete_run();
    end
endmodule
`default_nettype wire
